/* File: io_term_pkg.sv */
/*
 * constants, field layout, reset values and enumerations for the i/o
 * terminal function select block.
 * assumes a 10 MHz system clock and a plain address/strobe register port.
 */
// Overview of operation
// - digit one 0: keypad stop halts terminal run
// - keypad stop held until fwd/rev open or reference changes
// - digit one 1: keypad stop ignored during terminal run
// - digit two 1 rejects reverse from both sources
// - digit three picks double or single input scanning
// - digits 0/0: analog output follows output frequency
// - digits 1/0: analog output follows drive current
// - digits 0/1: analog output follows voltage reference
// - digits 1/1: analog output follows output power
// - encoder feedback mode ignores the fourth digit
// - stop method from two stop-and-source digits
package io_term_pkg;

    // timing
    localparam int unsigned CLK_HZ         = 10_000_000;  // system clock
    localparam int unsigned SCAN_PERIOD_NS = 2000;        // terminal scan
    localparam int unsigned SCAN_CYCLES    =
        (SCAN_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;

    // register port geometry
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned TERM_N = 8;                   // sequence inputs
    localparam int unsigned PCT_W  = 12;                  // analog scale

    // register offsets
    localparam logic [2:0] OFS_TERM_FUNC = 3'h0;  // terminal_function_param
    localparam logic [2:0] OFS_STOP_SRC  = 3'h1;  // stop_and_source_param
    localparam logic [2:0] OFS_AUX_SEL   = 3'h2;  // auxiliary_selector_param
    localparam logic [2:0] OFS_CTRL_MODE = 3'h3;  // control mode
    localparam logic [2:0] OFS_STATUS    = 3'h4;  // block status
    localparam logic [2:0] OFS_INPUTS    = 3'h5;  // scanned terminals

    // terminal_function_param digit positions
    localparam int unsigned TF_STOP_KEY = 0;      // keypad stop ignore
    localparam int unsigned TF_REV_OFF  = 1;      // reverse prohibited
    localparam int unsigned TF_SCAN_ONE = 2;      // single scan
    localparam int unsigned TF_AOUT     = 3;      // analog item digit
    // stop_and_source_param fields
    localparam int unsigned SS_METHOD_LO = 0;     // stop method, 2 bits
    localparam int unsigned SS_KEYPAD    = 2;     // run from keypad
    // status fields
    localparam int unsigned ST_HELD    = 0;
    localparam int unsigned ST_RUNNING = 1;
    localparam int unsigned ST_REV_REJ = 2;
    localparam int unsigned ST_ITEM_LO = 3;       // analog item, 2 bits

    // terminal assignments
    localparam int unsigned TERM_FWD    = 0;
    localparam int unsigned TERM_REV    = 1;
    localparam int unsigned TERM_REF_LO = 4;      // multi-step / jog
    localparam int unsigned TERM_REF_HI = 7;

    // reset values
    localparam logic [3:0] TF_RESET       = 4'h0;
    localparam logic [2:0] STOP_SRC_RESET = 3'h0;
    localparam logic       AUX_RESET      = 1'b0;

    typedef enum logic [1:0]
    {
        general_purpose_mode = 2'h0,
        sensorless_mode      = 2'h1,
        loop_regulation_mode = 2'h2,
        encoder_feedback_mode = 2'h3
    } ctrl_mode_e;

    typedef enum logic [1:0]
    {
        STOP_RAMP        = 2'h0,
        STOP_COAST       = 2'h1,
        STOP_DC_BRAKE    = 2'h2,
        STOP_COAST_TIMER = 2'h3
    } stop_method_e;

    typedef enum logic [1:0]
    {
        AOUT_FREQ    = 2'h0,
        AOUT_CURRENT = 2'h1,
        AOUT_VOLTAGE = 2'h2,
        AOUT_POWER   = 2'h3
    } aout_item_e;

    typedef enum logic [1:0]
    {
        LATCH_FREE = 2'b01,
        LATCH_HELD = 2'b10
    } latch_state_e;

endpackage : io_term_pkg

/* File: scan_if.sv */
/*
 * interface joining the controller and the terminal scanner.
 * assumes both ends run on the same system clock.
 */
interface scan_if #(
    parameter int unsigned N = 8
);
    logic         tick;        // one-cycle scan strobe
    logic         double_scan; // 1: two agreeing samples needed
    logic [N-1:0] raw;         // terminal levels
    logic [N-1:0] filt;        // accepted levels

    modport ctrl (output tick, output double_scan, output raw,
                  input filt);
    modport scan (input tick, input double_scan, input raw,
                  output filt);
endinterface : scan_if

/* File: term_scanner.sv */
/*
 * sequence input scanner: takes a sample on each scan strobe and accepts
 * a new level after one or two agreeing samples.
 * assumes the raw levels are synchronous to clk_in.
 */
module term_scanner
    import io_term_pkg::*;
#(
    parameter int unsigned N = 8
)
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // scanner side of the link
    scan_if.scan      sif
);

    logic [N-1:0] prev_q, prev_d;   // last sample taken
    logic [N-1:0] filt_q, filt_d;   // accepted levels

    // next sample and accepted level
    always_comb
    begin
        prev_d = prev_q;
        filt_d = filt_q;
        if (sif.tick)
        begin
            prev_d = sif.raw;
            // disagreeing bits keep their level, agreeing bits take it
            if (sif.double_scan)
                filt_d = (filt_q & (sif.raw ^ prev_q))
                       | (sif.raw & ~(sif.raw ^ prev_q));
            else
                filt_d = sif.raw;
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prev_q <= '0;
            filt_q <= '0;
        end
        else
        begin
            prev_q <= prev_d;
            filt_q <= filt_d;
        end
    end

    assign sif.filt = filt_q;

    // single scan copies the sample at once
    single_scan_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sif.tick && !sif.double_scan |=> filt_q == $past(sif.raw))
        else $error("single scan did not take the sample");

    // double scan never accepts a lone disagreeing sample
    double_agree_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sif.tick && sif.double_scan && (sif.raw != prev_q)
        |=> ((filt_q ^ $past(filt_q)) & ($past(sif.raw) ^ $past(prev_q)))
            == '0)
        else $error("double scan accepted an unconfirmed level");

endmodule : term_scanner

/* File: io_terminal_function_select.sv */
/*
 * operation-mode control for the i/o terminal function parameter: keypad
 * stop handling, reverse prohibit, input scan mode and analog item select.
 * assumes synchronous inputs, key_stop_in as a one-cycle press and
 * analog quantities already scaled to their own full scale.
 */
module io_terminal_function_select
    import io_term_pkg::*;
#(
    parameter int unsigned SCAN_DIV = SCAN_CYCLES
)
(
    // clock and reset
    input  wire logic                         clk_sys_in,
    input  wire logic                         rst_b_in,
    // register port
    input  wire logic [io_term_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [io_term_pkg::DATA_W-1:0] reg_wdata_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    output logic      [io_term_pkg::DATA_W-1:0] reg_rdata_out,
    // control terminals and keypad
    input  wire logic [io_term_pkg::TERM_N-1:0] term_raw_in,
    input  wire logic                         key_stop_in,
    input  wire logic                         key_run_in,
    input  wire logic                         key_rev_in,
    input  wire logic                         running_in,
    // analog quantities, each relative to its full scale
    input  wire logic [io_term_pkg::PCT_W-1:0]  freq_pct_in,
    input  wire logic [io_term_pkg::PCT_W-1:0]  cur_pct_in,
    input  wire logic [io_term_pkg::PCT_W-1:0]  volt_pct_in,
    input  wire logic [io_term_pkg::PCT_W-1:0]  pow_pct_in,
    // run and stop commands
    output logic                              forward_run_command_out,
    output logic                              reverse_run_command_out,
    output logic                              stop_req_out,
    output io_term_pkg::stop_method_e         stop_method_out,
    output logic                              stop_blink_out,
    output logic                              rev_reject_out,
    // analog output
    output io_term_pkg::aout_item_e           aout_item_out,
    output logic      [io_term_pkg::PCT_W-1:0]  aout_level_out,
    // accepted terminal levels
    output logic      [io_term_pkg::TERM_N-1:0] term_filt_out
);

    import io_term_pkg::*;

    // refuse a divider the counter cannot hold
    if (SCAN_DIV < 1 || SCAN_DIV > 65535)
    begin : g_bad_div
        $error("SCAN_DIV out of range");
    end

    // reset release through two flip-flops
    logic rst_m_q;                  // first stage
    logic rst_s_q;                  // synchronised reset, active low

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    // analog item from the fourth digit and the auxiliary digit
    function automatic aout_item_e pick_item(input logic dig4,
                                             input logic aux,
                                             input ctrl_mode_e mode);
        logic d;
        d = (mode == encoder_feedback_mode) ? 1'b0 : dig4;
        pick_item = aout_item_e'({aux, d});
    endfunction : pick_item

    // registers and control state
    logic [3:0]   tf_q, tf_d;          // terminal_function_param
    logic [2:0]   ss_q, ss_d;          // stop_and_source_param
    logic         aux_q, aux_d;        // auxiliary_selector_param
    ctrl_mode_e   mode_q, mode_d;      // control mode
    latch_state_e lat_q, lat_d;        // keypad stop latch
    logic [3:0]   ref_q, ref_d;        // last reference selection
    logic [15:0]  div_q, div_d;        // scan strobe divider
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic         fwd_q, fwd_d;
    logic         rev_q, rev_d;
    logic         rej_q, rej_d;
    aout_item_e   item_q, item_d;
    logic [PCT_W-1:0] lvl_q, lvl_d;

    // scanner link
    scan_if #(.N(TERM_N)) sif ();

    logic [TERM_N-1:0] filt;           // accepted terminal levels
    logic         tick;                // scan strobe
    logic         term_src;            // running from terminals
    logic         stop_take;           // keypad stop accepted
    logic         release_cond;        // latch may release
    logic         want_rev;            // reverse requested
    logic         want_fwd;            // forward requested
    logic         wr_ok;               // write permitted

    assign tick            = (div_q == 16'(SCAN_DIV - 1));
    assign sif.tick        = tick;
    assign sif.double_scan = ~tf_q[TF_SCAN_ONE];
    assign sif.raw         = term_raw_in;
    assign filt            = sif.filt;

    term_scanner #(.N(TERM_N)) u_scan
    (
        .clk_in   (clk_sys_in),
        .rst_b_in (rst_s_q),
        .sif      (sif)
    );

    // command path decode
    always_comb
    begin
        term_src  = ~ss_q[SS_KEYPAD];
        stop_take = key_stop_in && term_src && running_in
                  && !tf_q[TF_STOP_KEY];
        release_cond = (!filt[TERM_FWD] && !filt[TERM_REV])
                     || (filt[TERM_REF_HI:TERM_REF_LO] != ref_q);
        if (term_src)
        begin
            want_fwd = filt[TERM_FWD];
            want_rev = filt[TERM_REV] && !filt[TERM_FWD];
        end
        else
        begin
            want_fwd = key_run_in && !key_rev_in;
            want_rev = key_run_in && key_rev_in;
        end
        wr_ok = reg_wr_in && !running_in;
    end

    // next register values and command state
    always_comb
    begin
        tf_d    = tf_q;
        ss_d    = ss_q;
        aux_d   = aux_q;
        mode_d  = mode_q;
        lat_d   = lat_q;
        rdata_d = '0;
        ref_d   = filt[TERM_REF_HI:TERM_REF_LO];
        div_d   = tick ? 16'h0000 : div_q + 16'h0001;
        // register writes, only while stopped
        if (wr_ok)
        begin
            if (reg_addr_in == OFS_TERM_FUNC)
                tf_d = reg_wdata_in[3:0];
            else if (reg_addr_in == OFS_STOP_SRC)
                ss_d = reg_wdata_in[2:0];
            else if (reg_addr_in == OFS_AUX_SEL)
                aux_d = reg_wdata_in[0];
            else if (reg_addr_in == OFS_CTRL_MODE)
                mode_d = ctrl_mode_e'(reg_wdata_in[1:0]);
        end
        // register reads, answered next cycle
        if (reg_rd_in)
        begin
            if (reg_addr_in == OFS_TERM_FUNC)
                rdata_d = {4'h0, tf_q};
            else if (reg_addr_in == OFS_STOP_SRC)
                rdata_d = {5'h00, ss_q};
            else if (reg_addr_in == OFS_AUX_SEL)
                rdata_d = {7'h00, aux_q};
            else if (reg_addr_in == OFS_CTRL_MODE)
                rdata_d = {6'h00, mode_q};
            else if (reg_addr_in == OFS_STATUS)
                rdata_d = {3'h0, item_q, rej_q, running_in,
                           lat_q == LATCH_HELD};
            else if (reg_addr_in == OFS_INPUTS)
                rdata_d = filt;
            else
                rdata_d = '0;                               // unmapped
        end
        // keypad stop latch; a new stop wins over release
        case (lat_q)
            LATCH_FREE:
                if (stop_take)
                    lat_d = LATCH_HELD;
            LATCH_HELD:
                if (!stop_take && release_cond)
                    lat_d = LATCH_FREE;
            default:
                lat_d = LATCH_FREE;
        endcase
        // effective run commands
        fwd_d = want_fwd && (lat_d == LATCH_FREE);
        rev_d = want_rev && (lat_d == LATCH_FREE)
              && !tf_q[TF_REV_OFF];
        rej_d = want_rev && tf_q[TF_REV_OFF];
        // analog item and level
        item_d = pick_item(tf_q[TF_AOUT], aux_q, mode_q);
        case (item_d)
            AOUT_FREQ:    lvl_d = freq_pct_in;
            AOUT_CURRENT: lvl_d = cur_pct_in;
            AOUT_VOLTAGE: lvl_d = volt_pct_in;
            AOUT_POWER:   lvl_d = pow_pct_in;
            default:      lvl_d = freq_pct_in;
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys_in or negedge rst_s_q)
    begin
        if (!rst_s_q)
        begin
            tf_q    <= TF_RESET;
            ss_q    <= STOP_SRC_RESET;
            aux_q   <= AUX_RESET;
            mode_q  <= general_purpose_mode;
            lat_q   <= LATCH_FREE;
            ref_q   <= '0;
            div_q   <= '0;
            rdata_q <= '0;
            fwd_q   <= 1'b0;
            rev_q   <= 1'b0;
            rej_q   <= 1'b0;
            item_q  <= AOUT_FREQ;
            lvl_q   <= '0;
        end
        else
        begin
            tf_q    <= tf_d;
            ss_q    <= ss_d;
            aux_q   <= aux_d;
            mode_q  <= mode_d;
            lat_q   <= lat_d;
            ref_q   <= ref_d;
            div_q   <= div_d;
            rdata_q <= rdata_d;
            fwd_q   <= fwd_d;
            rev_q   <= rev_d;
            rej_q   <= rej_d;
            item_q  <= item_d;
            lvl_q   <= lvl_d;
        end
    end

    // outputs
    assign reg_rdata_out           = rdata_q;
    assign forward_run_command_out = fwd_q;
    assign reverse_run_command_out = rev_q;
    assign stop_req_out            = !(fwd_q || rev_q);
    assign stop_method_out         =
        stop_method_e'(ss_q[SS_METHOD_LO +: 2]);
    assign stop_blink_out          = (lat_q == LATCH_HELD);
    assign rev_reject_out          = rej_q;
    assign aout_item_out           = item_q;
    assign aout_level_out          = lvl_q;
    assign term_filt_out           = filt;

    // accepted keypad stop holds the drive stopped
    stop_key_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        stop_take |=> stop_blink_out && !forward_run_command_out
                      && !reverse_run_command_out)
        else $error("keypad stop did not stop the drive");

    // ignored keypad stop leaves the latch alone
    stop_ignore_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        tf_q[TF_STOP_KEY] && lat_q == LATCH_FREE |=> lat_q == LATCH_FREE)
        else $error("keypad stop taken while disabled");

    // latch holds until a release condition
    latch_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        lat_q == LATCH_HELD && !release_cond |=> lat_q == LATCH_HELD)
        else $error("stop latch released early");

    // prohibited reverse never reaches the output
    rev_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        tf_q[TF_REV_OFF] && want_rev |=> rev_reject_out
                                         && !reverse_run_command_out)
        else $error("reverse run not rejected");

    // scan mode follows the third digit
    scan_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        sif.double_scan == !tf_q[TF_SCAN_ONE])
        else $error("scan mode does not follow the digit");

    // analog level tracks the chosen quantity
    aout_freq_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        !aux_q && (!tf_q[TF_AOUT] || mode_q == encoder_feedback_mode)
        |=> aout_item_out == AOUT_FREQ && aout_level_out == $past(freq_pct_in))
        else $error("analog output not frequency");

    aout_cur_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        !aux_q && tf_q[TF_AOUT] && mode_q != encoder_feedback_mode
        |=> aout_level_out == $past(cur_pct_in))
        else $error("analog output not current");

    aout_pow_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        aux_q && tf_q[TF_AOUT] && mode_q != encoder_feedback_mode
        |=> aout_level_out == $past(pow_pct_in))
        else $error("analog output not power");

    // writes refused while running
    run_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_s_q)
        reg_wr_in && running_in |=> $stable(tf_q) && $stable(ss_q))
        else $error("parameter changed while running");

endmodule : io_terminal_function_select

/* File: term_keypad_model.sv */
/*
 * model of the control terminals and the keypad: registers the bench's
 * commands onto the block's inputs one clock later.
 * assumes the bench drives its commands just after a rising edge.
 */
module term_keypad_model
(
    // clock
    input  wire logic       clk_in,
    // commands from the bench
    input  wire logic       fwd_in,
    input  wire logic       rev_in,
    input  wire logic [3:0] ref_in,
    input  wire logic       stop_in,
    input  wire logic       run_in,
    input  wire logic       dir_rev_in,
    // terminal levels and keypad to the block
    output logic      [7:0] term_out,
    output logic            key_stop_out,
    output logic            key_run_out,
    output logic            key_rev_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // fault terminals stay open, so bits 3:2 are low
    always @(posedge clk_in)
    begin
        term_out     <= {ref_in, 2'h0, rev_in, fwd_in};
        key_stop_out <= stop_in;  // one-cycle press
        key_run_out  <= run_in;      // keypad run level
        key_rev_out  <= dir_rev_in;  // keypad direction level
    end
endmodule : term_keypad_model

/* File: io_terminal_function_select_tb.sv */
/*
 * self-checking bench for the i/o terminal function select block.
 * assumes a fast scan divider of 4 and the terminal model beside it.
 */
`define CHK(nm, exp, got) \
    begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module io_terminal_function_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import io_term_pkg::*;

    logic        clk_sys_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic [2:0]  addr       = 3'h0;
    logic [7:0]  wdata      = 8'h00;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic        running    = 1'b0;
    logic        forward_run_command        = 1'b0;
    logic        reverse_run_command        = 1'b0;
    logic [3:0]  ref_sel    = 4'h0;
    logic        stop_cmd   = 1'b0;
    logic        key_run_cmd = 1'b0;
    logic        key_rev_cmd = 1'b0;
    logic        key_run, key_rev;
    logic [7:0]  rdata, term_raw, filt;
    logic        key_stop, fwd_out, rev_out, stop_req, blink, rej;
    logic [11:0] level;
    stop_method_e method;
    aout_item_e   item;
    int          errors       = 0;
    int          total_checks = 0;

    // 100 ns clock
    always #50 clk_sys_in = ~clk_sys_in;

    term_keypad_model term_keypad_model_inst (.clk_in(clk_sys_in),
        .fwd_in(forward_run_command), .rev_in(reverse_run_command), .ref_in(ref_sel), .stop_in(stop_cmd),
        .run_in(key_run_cmd), .dir_rev_in(key_rev_cmd),
        .term_out(term_raw), .key_stop_out(key_stop),
        .key_run_out(key_run), .key_rev_out(key_rev));

    io_terminal_function_select #(.SCAN_DIV(4))
        io_terminal_function_select_inst (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .term_raw_in(term_raw), .key_stop_in(key_stop), .key_run_in(key_run),
        .key_rev_in(key_rev), .running_in(running), .freq_pct_in(12'h111),
        .cur_pct_in(12'h222), .volt_pct_in(12'h333), .pow_pct_in(12'h444),
        .forward_run_command_out(fwd_out), .reverse_run_command_out(rev_out),
        .stop_req_out(stop_req), .stop_method_out(method),
        .stop_blink_out(blink), .rev_reject_out(rej), .aout_item_out(item),
        .aout_level_out(level), .term_filt_out(filt));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick

    // one-cycle write strobe
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask : reg_wr

    // read strobe, data compared in the following cycle only
    task automatic reg_chk(input logic [2:0] a, input logic [7:0] e);
        addr <= a;
        rd   <= 1'b1;
        tick(1);
        rd <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask : reg_chk

    // press the keypad stop key once
    task automatic press;
        stop_cmd <= 1'b1;
        tick(1);
        stop_cmd <= 1'b0;
        tick(3);
    endtask : press

    task automatic t_reset;
        reg_chk(OFS_TERM_FUNC, 8'h00);
        reg_chk(OFS_STOP_SRC, 8'h00);
        reg_chk(3'h6, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_analog;
        logic [11:0] lv [4] = '{12'h111, 12'h222, 12'h333, 12'h444};
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(OFS_TERM_FUNC, {4'h0, i[0], 3'h0});
            reg_wr(OFS_AUX_SEL, {7'h00, i[1]});
            tick(3);
            `CHK("item", aout_item_e'(i), item)
            `CHK("level", lv[i], level)
        end
        // encoder mode: fourth digit set but frequency still chosen
        reg_wr(OFS_CTRL_MODE, 8'h03);
        reg_wr(OFS_AUX_SEL, 8'h00);
        tick(3);
        `CHK("enc item", AOUT_FREQ, item)
        `CHK("enc level", 12'h111, level)
        reg_chk(OFS_CTRL_MODE, 8'h03);
        reg_wr(OFS_CTRL_MODE, 8'h00);
        $display("test analog done");
    endtask : t_analog

    task automatic t_method;
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(OFS_STOP_SRC, {6'h00, i[1:0]});
            tick(2);
            `CHK("method", stop_method_e'(i), method)
        end
        reg_wr(OFS_STOP_SRC, 8'h00);
        $display("test method done");
    endtask : t_method

    // a terminal pulse of len cycles; seen records any acceptance of it
    // (a four-cycle pulse meets exactly one scan strobe)
    task automatic t_scan(input logic [7:0] tf, input int len,
                          input logic e);
        logic seen;
        seen = 1'b0;
        reg_wr(OFS_TERM_FUNC, tf);
        tick(12);
        for (int c = 0; c < len + 12; c++)
        begin
            forward_run_command <= (c < len);
            @(negedge clk_sys_in);
            seen = seen | filt[0];
            @(posedge clk_sys_in);
        end
        `CHK("filt", e, seen)
        tick(12);
        $display("test scan done");
    endtask : t_scan

    task automatic t_stop;
        reg_wr(OFS_TERM_FUNC, 8'h00);
        forward_run_command     <= 1'b1;
        running <= 1'b1;
        tick(12);
        `CHK("fwd run", 1'b1, fwd_out)
        press();
        `CHK("blink", 1'b1, blink)
        `CHK("stopped", 1'b0, fwd_out)
        `CHK("stop_req", 1'b1, stop_req)
        reg_wr(OFS_TERM_FUNC, 8'h01);
        reg_chk(OFS_TERM_FUNC, 8'h00);
        tick(12);
        `CHK("held", 1'b1, blink)
        ref_sel <= 4'h1;
        tick(12);
        `CHK("ref free", 1'b0, blink)
        `CHK("rerun", 1'b1, fwd_out)
        press();
        forward_run_command <= 1'b0;
        tick(12);
        `CHK("open free", 1'b0, blink)
        running <= 1'b0;
        reg_wr(OFS_TERM_FUNC, 8'h01);
        forward_run_command     <= 1'b1;
        running <= 1'b1;
        tick(12);
        press();
        `CHK("ignored", 1'b0, blink)
        `CHK("run on", 1'b1, fwd_out)
        running <= 1'b0;
        forward_run_command     <= 1'b0;
        $display("test stop done");
    endtask : t_stop

    task automatic t_rev;
        reg_wr(OFS_TERM_FUNC, 8'h02);
        reverse_run_command <= 1'b1;
        tick(12);
        `CHK("rev off", 1'b0, rev_out)
        `CHK("reject", 1'b1, rej)
        reg_chk(OFS_STATUS, 8'h04);
        reg_chk(OFS_INPUTS, 8'h12);
        reg_wr(OFS_TERM_FUNC, 8'h00);
        tick(3);
        `CHK("rev on", 1'b1, rev_out)
        reverse_run_command <= 1'b0;
        // keypad source: reverse refused, then accepted
        reg_wr(OFS_STOP_SRC, 8'h04);
        reg_wr(OFS_TERM_FUNC, 8'h02);
        key_run_cmd <= 1'b1;
        key_rev_cmd <= 1'b1;
        tick(3);
        `CHK("key rev off", 1'b0, rev_out)
        `CHK("key reject", 1'b1, rej)
        reg_wr(OFS_TERM_FUNC, 8'h00);
        tick(3);
        `CHK("key rev on", 1'b1, rev_out)
        key_rev_cmd <= 1'b0;
        tick(3);
        `CHK("key fwd", 1'b1, fwd_out)
        key_run_cmd <= 1'b0;
        reg_wr(OFS_STOP_SRC, 8'h00);
        $display("test reverse done");
    endtask : t_rev

    // reset while stopped brings every digit back to zero
    task automatic t_rerst;
        reg_wr(OFS_TERM_FUNC, 8'h0F);
        reg_chk(OFS_TERM_FUNC, 8'h0F);
        tick(1);
        rst_b_in <= 1'b0;
        tick(2);
        `CHK("rst stop_req", 1'b1, stop_req)
        rst_b_in <= 1'b1;
        tick(3);
        reg_chk(OFS_TERM_FUNC, 8'h00);
        $display("test reset again done");
    endtask : t_rerst

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // watchdog well beyond the expected run
    initial
    begin
        #2_000_000;
        errors++;
        give_verdict();
    end

    initial
    begin
        tick(3);
        rst_b_in <= 1'b1;
        tick(3);
        t_reset();
        t_analog();
        t_method();
        t_scan(8'h00, 4, 1'b0);
        t_scan(8'h04, 4, 1'b1);
        t_scan(8'h00, 12, 1'b1);
        t_stop();
        t_rev();
        t_rerst();
        give_verdict();
    end
endmodule : io_terminal_function_select_tb
